// ===== verilog/adcr_pkg.sv
// Shared constants and types for the serial converter readout link
package adcr_pkg;

    localparam int CLK_PERIOD_NS = 8;
    localparam int RES_BITS      = 12;

    // Conversion time is a longest time: round down
    localparam int CONV_TIME_NS  = 8500;
    localparam int CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam logic [6:0]  SAR_STEP_CYC    = 7'(CONV_CYC / RES_BITS);
    localparam logic [3:0]  SAR_MSB         = 4'(RES_BITS - 1);
    localparam logic [11:0] SAR_FIRST_TRIAL = 12'h0800;
    localparam logic [4:0]  LAST_DATA_EDGE  = 5'(RES_BITS);
    localparam logic [4:0]  EDGE_CNT_SAT    = 5'h1f;

    // Host side waits are least times: round up
    localparam int ACQ_TIME_NS     = 1500;
    localparam int ACQ_CYC         = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEL_HIGH_NS     = 500;
    localparam int SEL_HIGH_CYC    = (SEL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [10:0] HOLDOFF_CYC = 11'((ACQ_CYC > SEL_HIGH_CYC) ? ACQ_CYC : SEL_HIGH_CYC);
    localparam int SYNC_MARGIN_CYC = 8;
    localparam logic [10:0] CONV_WAIT_CYC =
        11'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_MARGIN_CYC);
    localparam logic [10:0] EOC_GUARD_CYC = 11'(SYNC_MARGIN_CYC);

    localparam int SCLK_MAX_KHZ    = 2500;
    localparam int SCLK_HALF_NS    = 1000000 / (2 * SCLK_MAX_KHZ);
    localparam int MIN_PHASE_NS    = 100;
    localparam int HALF_NS         = (SCLK_HALF_NS > MIN_PHASE_NS) ? SCLK_HALF_NS : MIN_PHASE_NS;
    localparam logic [10:0] SCLK_HALF_CYC = 11'((HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    localparam logic [4:0] FRAME_CLKS_STREAM = 5'(RES_BITS + 1);
    localparam logic [4:0] FRAME_CLKS_BYTES  = 5'(2 * 8);

    localparam logic        CS_N_RST   = 1'b1;
    localparam logic [11:0] RESULT_RST = 12'h0000;

    typedef enum logic [1:0] {DV_IDLE, DV_CONV, DV_READY} adcr_dev_state_t;
    typedef enum logic [2:0] {HS_IDLE, HS_WAIT, HS_LOW, HS_HIGH, HS_END, HS_GAP} adcr_host_state_t;

    typedef struct packed {
        logic            sel_s1;
        logic            sel_s2;
        logic            sel_d;
        logic            tgl_s1;
        logic            tgl_s2;
        logic            tgl_d;
        adcr_dev_state_t state;
        logic [11:0]     held;
        logic [11:0]     sar;
        logic [3:0]      bit_idx;
        logic [6:0]      step_cnt;
        logic [4:0]      edge_cnt;
        logic            dout;
        logic            dout_oe;
        logic [11:0]     result;
        logic            done;
        logic            busy;
    } adcr_dev_st_t;

    typedef struct packed {
        logic tgl;
    } adcr_lnk_st_t;

    typedef struct packed {
        logic             d_s1;
        logic             d_s2;
        logic             d_prev;
        adcr_host_state_t state;
        logic [10:0]      cnt;
        logic [4:0]       clks;
        logic [4:0]       target;
        logic [12:0]      shreg;
        logic             cs_n;
        logic             sclk;
        logic [11:0]      result;
        logic             valid;
        logic             busy;
        logic             marker_err;
        logic             aborted;
    } adcr_host_st_t;

endpackage

// ===== verilog/adcr_link_if.sv
// Three-wire link between the converter end and the serial master end
`timescale 1ns/10ps
`default_nettype none
interface adcr_link_if;
    logic select_n;
    logic sclk;
    logic dout;
    logic dout_oe;
    logic dout_line;

    // Released data line is modelled as pulled low
    assign dout_line = dout_oe & dout;

    modport dev (
        input  select_n,
        input  sclk,
        output dout,
        output dout_oe
    );
    modport hst (
        output select_n,
        output sclk,
        input  dout_line
    );
endinterface
`default_nettype wire

// ===== verilog/adcr_device.sv
// Converter end: conversion timing, result register and serial shift-out
`timescale 1ns/10ps
`default_nettype none
module adcr_device (
    input  wire logic     clk_in,
    input  wire logic     srst_in,
    adcr_link_if.dev      link,
    input  wire logic [11:0] sample_code_in,
    output logic [11:0]   result_out,
    output logic          done_out,
    output logic          busy_out
);
    adcr_pkg::adcr_dev_st_t st_ff;
    adcr_pkg::adcr_dev_st_t nxt_st;
    // Shift clock only runs inside frames, so its flop gets a power-up value, not a reset
    adcr_pkg::adcr_lnk_st_t lnk_ff = '0;
    adcr_pkg::adcr_lnk_st_t nxt_lnk;

    function automatic logic [11:0] bit_mask(input logic [3:0] idx);
        bit_mask = 12'h0001 << idx;
    endfunction

    function automatic logic pick_bit(input logic [11:0] word, input logic [4:0] n);
        if (n >= 5'h01 && n <= adcr_pkg::LAST_DATA_EDGE) begin
            pick_bit = word[4'(adcr_pkg::LAST_DATA_EDGE - n)];
        end else begin
            pick_bit = 1'b0;
        end
    endfunction

    // Each falling shift-clock edge flips a toggle; the clock domain counts the flips
    always_comb begin
        nxt_lnk     = lnk_ff;
        nxt_lnk.tgl = ~lnk_ff.tgl;
    end

    always_ff @(negedge link.sclk) begin
        lnk_ff <= nxt_lnk;
    end

    always_comb begin
        logic        sel_fall;
        logic        edge_seen;
        logic [11:0] trial;
        logic [4:0]  ecnt;
        sel_fall  = 1'b0;
        edge_seen = 1'b0;
        trial     = 12'h0000;
        ecnt      = 5'h00;
        nxt_st        = st_ff;
        nxt_st.done   = 1'b0;
        nxt_st.sel_s1 = link.select_n;
        nxt_st.sel_s2 = st_ff.sel_s1;
        nxt_st.sel_d  = st_ff.sel_s2;
        nxt_st.tgl_s1 = lnk_ff.tgl;
        nxt_st.tgl_s2 = st_ff.tgl_s1;
        nxt_st.tgl_d  = st_ff.tgl_s2;
        sel_fall  = st_ff.sel_d & ~st_ff.sel_s2;
        edge_seen = st_ff.tgl_s2 ^ st_ff.tgl_d;
        if (srst_in) begin
            nxt_st         = '0;
            nxt_st.sel_s1  = 1'b1;
            nxt_st.sel_s2  = 1'b1;
            nxt_st.sel_d   = 1'b1;
            nxt_st.state   = adcr_pkg::DV_IDLE;
            nxt_st.result  = adcr_pkg::RESULT_RST;
            // Toggle sync keeps running in reset so release never shows a false edge
            nxt_st.tgl_s1  = lnk_ff.tgl;
            nxt_st.tgl_s2  = st_ff.tgl_s1;
            nxt_st.tgl_d   = st_ff.tgl_s2;
        end else if (st_ff.sel_s2) begin
            // Deselect releases the line and aborts any conversion
            nxt_st.state   = adcr_pkg::DV_IDLE;
            nxt_st.dout_oe = 1'b0;
            nxt_st.dout    = 1'b0;
            nxt_st.busy    = 1'b0;
        end else begin
            unique case (st_ff.state)
                adcr_pkg::DV_IDLE: begin
                    if (sel_fall) begin
                        nxt_st.held     = sample_code_in;
                        nxt_st.sar      = adcr_pkg::SAR_FIRST_TRIAL;
                        nxt_st.bit_idx  = adcr_pkg::SAR_MSB;
                        nxt_st.step_cnt = 7'h00;
                        nxt_st.dout_oe  = 1'b1;
                        nxt_st.dout     = 1'b0;
                        nxt_st.busy     = 1'b1;
                        nxt_st.state    = adcr_pkg::DV_CONV;
                    end
                end
                adcr_pkg::DV_CONV: begin
                    // Shift-clock edges here are ignored; timing comes from clk_in only
                    nxt_st.step_cnt = st_ff.step_cnt + 7'h01;
                    if (st_ff.step_cnt == adcr_pkg::SAR_STEP_CYC - 7'h01) begin
                        nxt_st.step_cnt = 7'h00;
                        trial = st_ff.sar;
                        // Plain binary code of the held sample, one bit per step
                        if (trial > st_ff.held) begin
                            trial = trial & ~bit_mask(st_ff.bit_idx);
                        end
                        if (st_ff.bit_idx == 4'h0) begin
                            nxt_st.result   = trial;
                            nxt_st.dout     = 1'b1;
                            nxt_st.edge_cnt = 5'h00;
                            nxt_st.done     = 1'b1;
                            nxt_st.busy     = 1'b0;
                            nxt_st.state    = adcr_pkg::DV_READY;
                        end else begin
                            nxt_st.sar     = trial | bit_mask(st_ff.bit_idx - 4'h1);
                            nxt_st.bit_idx = st_ff.bit_idx - 4'h1;
                        end
                    end
                end
                adcr_pkg::DV_READY: begin
                    if (edge_seen) begin
                        ecnt = st_ff.edge_cnt;
                        if (ecnt != adcr_pkg::EDGE_CNT_SAT) begin
                            ecnt = ecnt + 5'h01;
                        end
                        nxt_st.edge_cnt = ecnt;
                        // MSB first, then zeros forever until deselect
                        nxt_st.dout = pick_bit(st_ff.result, ecnt);
                    end
                end
                default: begin
                    nxt_st.state = adcr_pkg::DV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        st_ff <= nxt_st;
    end

    assign link.dout    = st_ff.dout;
    assign link.dout_oe = st_ff.dout_oe;
    assign result_out   = st_ff.result;
    assign done_out     = st_ff.done;
    assign busy_out     = st_ff.busy;
endmodule
`default_nettype wire

// ===== verilog/adcr_host.sv
// Serial master end: starts conversions and collects 12-bit results
//
// Function
// - Select fall holds sample, starts, drives low
// - Host keeps shift clock idle while converting
// - Result built in an internal holding register
// - Data line rises high at end of conversion
// - Result shifts out any time, shift clock only
// - Falling edges present MSB first, then descending
// - Host gives at least thirteen falling edges
// - Extra edges give zeros, harmless to converter
// - Deselect after last bit for shortest cycle
// - Result is plain unsigned binary, 4096 codes
// - Host makes shift clock, at most 2.5MHz
// - Host pulls select low, shift clock low
// - Wait max conversion time or data rising
// - Host samples each bit on rising edge
// - Deselect at or after thirteenth falling edge
// - Hold select high minimum interval before restart; host may restart at once after srst_in
// - Early deselect aborts; wait acquisition before restart
// - Read as byte bursts or one stream
// - Conversion self-timed, done within 8.5us
// - Shift clock phases each at least 100ns
// - Clock idles low, sampled on rising edges
// - Acquisition interval never below 1.5us; after srst_in the host may start at once
`timescale 1ns/10ps
`default_nettype none
module adcr_host (
    input  wire logic     clk_in,
    input  wire logic     srst_in,
    adcr_link_if.hst      link,
    input  wire logic     start_in,
    input  wire logic     abort_in,
    input  wire logic     byte_mode_in,
    output logic [11:0]   result_out,
    output logic          valid_out,
    output logic          busy_out,
    output logic          marker_err_out,
    output logic          aborted_out
);
    adcr_pkg::adcr_host_st_t st_ff;
    adcr_pkg::adcr_host_st_t nxt_st;

    function automatic logic half_done(input logic [10:0] cnt);
        half_done = (cnt == adcr_pkg::SCLK_HALF_CYC - 11'h001);
    endfunction

    always_comb begin
        logic eoc_rise;
        eoc_rise = 1'b0;
        nxt_st         = st_ff;
        nxt_st.valid   = 1'b0;
        nxt_st.aborted = 1'b0;
        // Data line is asynchronous to clk_in: two flops before use
        nxt_st.d_s1    = link.dout_line;
        nxt_st.d_s2    = st_ff.d_s1;
        nxt_st.d_prev  = st_ff.d_s2;
        eoc_rise       = st_ff.d_s2 & ~st_ff.d_prev;
        if (srst_in) begin
            nxt_st        = '0;
            nxt_st.cs_n   = adcr_pkg::CS_N_RST;
            nxt_st.state  = adcr_pkg::HS_IDLE;
            nxt_st.result = adcr_pkg::RESULT_RST;
        end else begin
            unique case (st_ff.state)
                adcr_pkg::HS_IDLE: begin
                    if (start_in) begin
                        nxt_st.cs_n   = 1'b0;
                        nxt_st.sclk   = 1'b0;
                        nxt_st.cnt    = 11'h000;
                        nxt_st.clks   = 5'h00;
                        nxt_st.shreg  = 13'h0000;
                        nxt_st.busy   = 1'b1;
                        // Two bytes pad with zeros; stream stops at the last bit
                        nxt_st.target = byte_mode_in ? adcr_pkg::FRAME_CLKS_BYTES
                                                     : adcr_pkg::FRAME_CLKS_STREAM;
                        nxt_st.state  = adcr_pkg::HS_WAIT;
                    end
                end
                adcr_pkg::HS_WAIT: begin
                    // Clock stays idle for the whole conversion
                    nxt_st.cnt = st_ff.cnt + 11'h001;
                    if (abort_in) begin
                        nxt_st.cs_n    = 1'b1;
                        nxt_st.cnt     = 11'h000;
                        nxt_st.aborted = 1'b1;
                        nxt_st.state   = adcr_pkg::HS_GAP;
                    end else if ((st_ff.cnt >= adcr_pkg::EOC_GUARD_CYC && eoc_rise) ||
                                 st_ff.cnt == adcr_pkg::CONV_WAIT_CYC) begin
                        // Guard masks stale line level seen just after select fall
                        nxt_st.cnt   = 11'h000;
                        nxt_st.state = adcr_pkg::HS_LOW;
                    end
                end
                adcr_pkg::HS_LOW: begin
                    nxt_st.cnt = st_ff.cnt + 11'h001;
                    if (half_done(st_ff.cnt)) begin
                        nxt_st.sclk = 1'b1;
                        nxt_st.cnt  = 11'h000;
                        nxt_st.clks = st_ff.clks + 5'h01;
                        if (st_ff.clks < adcr_pkg::FRAME_CLKS_STREAM) begin
                            // Sample taken at our own rising edge, bit stable for a half period
                            nxt_st.shreg = {st_ff.shreg[11:0], st_ff.d_s2};
                        end
                        nxt_st.state = adcr_pkg::HS_HIGH;
                    end
                end
                adcr_pkg::HS_HIGH: begin
                    nxt_st.cnt = st_ff.cnt + 11'h001;
                    if (half_done(st_ff.cnt)) begin
                        nxt_st.sclk  = 1'b0;
                        nxt_st.cnt   = 11'h000;
                        nxt_st.state = (st_ff.clks == st_ff.target) ? adcr_pkg::HS_END
                                                                    : adcr_pkg::HS_LOW;
                    end
                end
                adcr_pkg::HS_END: begin
                    nxt_st.cnt = st_ff.cnt + 11'h001;
                    if (half_done(st_ff.cnt)) begin
                        nxt_st.cs_n       = 1'b1;
                        nxt_st.cnt        = 11'h000;
                        nxt_st.result     = st_ff.shreg[11:0];
                        nxt_st.marker_err = ~st_ff.shreg[12];
                        nxt_st.valid      = 1'b1;
                        nxt_st.state      = adcr_pkg::HS_GAP;
                    end
                end
                adcr_pkg::HS_GAP: begin
                    // One holdoff covers both select-high and acquisition minimums
                    nxt_st.cnt = st_ff.cnt + 11'h001;
                    if (st_ff.cnt == adcr_pkg::HOLDOFF_CYC - 11'h001) begin
                        nxt_st.busy  = 1'b0;
                        nxt_st.state = adcr_pkg::HS_IDLE;
                    end
                end
                default: begin
                    nxt_st.cs_n  = 1'b1;
                    nxt_st.sclk  = 1'b0;
                    nxt_st.busy  = 1'b0;
                    nxt_st.state = adcr_pkg::HS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        st_ff <= nxt_st;
    end

    assign link.select_n  = st_ff.cs_n;
    assign link.sclk      = st_ff.sclk;
    assign result_out     = st_ff.result;
    assign valid_out      = st_ff.valid;
    assign busy_out       = st_ff.busy;
    assign marker_err_out = st_ff.marker_err;
    assign aborted_out    = st_ff.aborted;
endmodule
`default_nettype wire

// ===== verification/adcr_link_monitor.sv
// Checker on the three-wire link between the converter end and the serial master end
`timescale 1ns/10ps
`default_nettype none
module adcr_link_monitor (
    input  wire logic clk_in,
    input  wire logic srst_in,
    input  wire logic select_n,
    input  wire logic sclk,
    input  wire logic dout,
    input  wire logic dout_oe,
    input  wire logic dout_line
);
    logic [10:0] conv_cnt_ff;
    logic [4:0]  fall_age_ff;
    logic [4:0]  falls_ff;
    logic [4:0]  phase_ff;
    logic        sclk_d_ff;
    wire  logic  sclk_fell = sclk_d_ff & ~sclk;

    // Saturating counters so a stuck link never wraps back into a checked window
    always_ff @(posedge clk_in) begin
        sclk_d_ff   <= srst_in ? 1'b0 : sclk;
        conv_cnt_ff <= (srst_in | select_n) ? 11'h000 : conv_cnt_ff + 11'(conv_cnt_ff != 11'h7ff);
        fall_age_ff <= (srst_in | sclk_fell) ? 5'h00 : fall_age_ff + 5'(fall_age_ff != 5'h1f);
        falls_ff    <= (srst_in | select_n) ? 5'h00 : falls_ff + 5'(sclk_fell & (falls_ff != 5'h1f));
        phase_ff    <= (srst_in | (sclk != sclk_d_ff)) ? 5'h01 : phase_ff + 5'(phase_ff != 5'h1f);
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    sequence s_sel_fall;
        $fell(select_n);
    endsequence
    sequence s_driven_low;
        dout_oe && !dout;
    endsequence

    a_start_drive_low: assert property (s_sel_fall |-> ##[2:6] s_driven_low)
        else $error("data line not driven low after select fall");
    a_conv_holds_low: assert property ((conv_cnt_ff >= 11'h008 && conv_cnt_ff <= 11'h41a) |-> s_driven_low)
        else $error("data line left low state during conversion");
    a_sclk_idle_conv: assert property ((conv_cnt_ff != 11'h000 && conv_cnt_ff < 11'h426) |-> !sclk)
        else $error("shift clock active during conversion");
    a_eoc_in_time: assert property ((conv_cnt_ff == 11'h426) |-> dout_line)
        else $error("end of conversion not signalled in time");
    a_marker_first: assert property ((falls_ff == 5'h00 && conv_cnt_ff > 11'h428 && !select_n) |-> dout_line)
        else $error("leading high bit missing before first fall");
    a_bits_on_fall: assert property (($changed(dout_line) && !select_n && conv_cnt_ff > 11'h42e) |->
        (fall_age_ff >= 5'h01 && fall_age_ff <= 5'h06))
        else $error("data changed away from a shift clock fall");
    a_stable_clk_high: assert property ((sclk && $past(sclk) && !select_n) |-> $stable(dout_line))
        else $error("data moved while shift clock high");
    a_trailing_zeros: assert property ((falls_ff >= 5'h0d && fall_age_ff >= 5'h06 && !select_n) |-> !dout_line)
        else $error("nonzero data after last result bit");
    a_idle_clock_low: assert property (select_n |-> !sclk)
        else $error("shift clock not idle low while deselected");
    a_phase_min: assert property ((sclk != sclk_d_ff) |-> (phase_ff >= 5'h0d))
        else $error("shift clock phase too short");
    a_release_high: assert property ($rose(select_n) |-> ##[1:6] !dout_oe)
        else $error("data line not released after deselect");
endmodule
`default_nettype wire

// ===== verification/adc_serial_conversion_readout_bench.sv
// Self-checking bench joining the converter end and the serial master end
`timescale 1ns/10ps
`default_nettype none
module adc_serial_conversion_readout_bench;
    logic        clk_in         = 1'b0;
    logic        srst_in        = 1'b1;
    logic        start_in       = 1'b0;
    logic        abort_in       = 1'b0;
    logic        byte_mode_in   = 1'b0;
    logic [11:0] sample_code_in = 12'h000;
    logic [11:0] h_result;
    logic [11:0] d_result;
    logic        valid;
    logic        h_busy;
    logic        marker_err;
    logic        aborted;
    logic        done;
    logic        d_busy;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cycles    = 0;
    int          rises     = 0;
    int          dones     = 0;

    adcr_link_if link ();
    adcr_device adcr_device_i (.clk_in(clk_in), .srst_in(srst_in), .link(link),
        .sample_code_in(sample_code_in), .result_out(d_result), .done_out(done), .busy_out(d_busy));
    adcr_host adcr_host_i (.clk_in(clk_in), .srst_in(srst_in), .link(link), .start_in(start_in),
        .abort_in(abort_in), .byte_mode_in(byte_mode_in), .result_out(h_result), .valid_out(valid),
        .busy_out(h_busy), .marker_err_out(marker_err), .aborted_out(aborted));
    adcr_link_monitor adcr_link_monitor_i (.clk_in(clk_in), .srst_in(srst_in), .select_n(link.select_n),
        .sclk(link.sclk), .dout(link.dout), .dout_oe(link.dout_oe), .dout_line(link.dout_line));

    initial forever #4 clk_in = ~clk_in;

    task automatic summarize();
        $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Ceiling well above nine frames of about two thousand cycles each, plus the abort and reset tests
    always @(posedge clk_in) begin
        cycles++;
        if (done === 1'b1) dones++;
        if (cycles == 40000) begin
            bad_count++;
            $display("[ERR] %0t run timed out", $time);
            summarize();
        end
    end
    always @(negedge link.select_n) rises = 0;
    always @(posedge link.sclk) rises++;

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic pulse_start(input logic [11:0] code, input logic bm);
        sample_code_in = code;
        byte_mode_in   = bm;
        start_in       = 1'b1;
        @(negedge clk_in);
        start_in = 1'b0;
    endtask
    // Spent: cycles already waited since select rose
    task automatic wait_idle(input int spent);
        int n;
        int hold;
        hold = int'(adcr_pkg::HOLDOFF_CYC);
        for (n = 0; n < 400 && h_busy !== 1'b0; n++) @(negedge clk_in);
        chk_bit((n >= hold - spent - 1) && (n <= hold - spent + 1), 1'b1);
    endtask

    task automatic t_frame(input logic [11:0] code, input logic bm, input string name);
        int n;
        int d0;
        d0 = dones;
        pulse_start(code, bm);
        for (n = 0; n < 3000 && valid !== 1'b1; n++) @(negedge clk_in);
        chk_bit(valid, 1'b1);
        chk(h_result, code);
        chk(d_result, code);
        chk_bit(marker_err, 1'b0);
        chk(12'(rises), bm ? 12'h010 : 12'h00d);
        chk(12'(dones - d0), 12'h001);
        chk_bit(link.select_n, 1'b1);
        wait_idle(0);
        $display("test %s done", name);
    endtask

    // Select raised mid-conversion: no result, no completion, line released
    task automatic t_abort();
        int n;
        int d0;
        logic [11:0] prev;
        d0   = dones;
        prev = h_result;
        pulse_start(12'h3c3, 1'b0);
        repeat (300) @(negedge clk_in);
        chk_bit(d_busy, 1'b1);
        abort_in = 1'b1;
        for (n = 0; n < 10 && aborted !== 1'b1; n++) @(negedge clk_in);
        abort_in = 1'b0;
        chk_bit(aborted, 1'b1);
        chk_bit(link.select_n, 1'b1);
        repeat (8) @(negedge clk_in);
        chk_bit(link.dout_oe, 1'b0);
        chk_bit(d_busy, 1'b0);
        chk(12'(dones - d0), 12'h000);
        chk(h_result, prev);
        wait_idle(8);
        $display("test abort done");
    endtask

    // Reset in mid-conversion returns both ends to their idle levels
    task automatic t_reset();
        pulse_start(12'h5a5, 1'b0);
        repeat (200) @(negedge clk_in);
        srst_in = 1'b1;
        repeat (12) @(negedge clk_in);
        chk_bit(link.select_n, 1'b1);
        chk_bit(link.dout_oe, 1'b0);
        chk_bit(h_busy | d_busy, 1'b0);
        chk(d_result, 12'h000);
        srst_in = 1'b0;
        $display("test reset done");
    endtask

    initial begin
        repeat (12) @(negedge clk_in);
        srst_in = 1'b0;
        t_frame(12'h000, 1'b0, "zero");
        t_frame(12'hfff, 1'b0, "full");
        t_frame(12'h800, 1'b0, "mid");
        t_frame(12'h7ff, 1'b0, "below_mid");
        t_frame(12'ha5c, 1'b0, "pattern");
        t_frame(12'h5a3, 1'b1, "bytes");
        t_frame(12'hfff, 1'b1, "bytes_full");
        t_abort();
        t_frame(12'h001, 1'b0, "after_abort");
        t_reset();
        t_frame(12'h123, 1'b0, "after_reset");
        summarize();
    end
endmodule
`default_nettype wire
